/* File: hw/acs_cfg.svh */
// Constants for the converter mode control and serial port
// ==========================================================
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_CFG_RESET 16'h058B
`define ACS_BIT_SS 15
`define ACS_BIT_MODE 8
`define ACS_BIT_TS 4
`define ACS_DR_HI 7
`define ACS_DR_LO 5
`define ACS_CLK_HZ 40000000
`define ACS_OSC_HZ 1000000
`define ACS_TIMEOUT_MS 28
`define ACS_EARLY_US 8
`endif

/* File: hw/acs_pkg.sv */
// Types for the converter mode control and serial port
package acs_pkg;
  typedef enum logic [1:0] {ACS_OFF, ACS_CONV, ACS_RUN} acs_state_t;
  typedef logic [15:0] acs_word_t;
endpackage : acs_pkg

/* File: hw/acs_xfer_if.sv */
// Crossing bundle between core and serial-clock domain
`timescale 1ns/100ps
interface acs_xfer_if;
  logic [15:0] tx_result;
  logic cfg_seen;
  logic [15:0] rx_config;
  logic start_seen;
  modport core (output tx_result, input cfg_seen, input rx_config,
    input start_seen);
  modport link (input tx_result, output cfg_seen, output rx_config,
    output start_seen);
endinterface : acs_xfer_if

/* File: hw/acs_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module acs_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : acs_sync

/* File: hw/acs_link.sv */
// Shift logic on the serial clock
`timescale 1ns/100ps
module acs_link (
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic shift_bit,
  // Timeout reset from core domain
  input wire logic port_clear,
  // Crossing bundle
  acs_xfer_if.link x
);
  logic [31:0] shreg;
  logic [15:0] rxreg;
  logic [5:0] count;
  logic [4:0] fcount;
  wire clr = cs_n | port_clear;
  // Readback of the word just captured, as the core stores it
  wire [15:0] readback = {1'b0, x.rx_config[14:1], 1'b1};
  // Rising edge: result at first edge, readback at the 17th
  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      count <= 6'h00;
      shift_bit <= 1'b0;
      shreg <= 32'h00000000;
      x.start_seen <= 1'b0;
    end else begin
      if (count == 6'h00) begin
        shift_bit <= x.tx_result[15];
        shreg <= {x.tx_result[14:0], 17'h00000};
        x.start_seen <= 1'b1;
      end else if (count == 6'h10) begin
        shift_bit <= readback[15];
        shreg <= {readback[14:0], 17'h00000};
      end else begin
        shift_bit <= shreg[31];
        shreg <= {shreg[30:0], 1'b0};
      end
      if (count != 6'h20) begin
        count <= count + 6'h01;
      end
    end
  end
  // Flags are levels: the core sees a rise, a cleared port never
  // fakes one; select must stay high a few core clocks between uses
  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      fcount <= 5'h00;
      rxreg <= 16'h0000;
      x.cfg_seen <= 1'b0;
    end else begin
      rxreg <= {rxreg[14:0], serial_in};
      if (fcount != 5'h1F) begin
        fcount <= fcount + 5'h01;
      end
      if (fcount == 5'h0F) begin
        x.cfg_seen <= 1'b1;
      end
    end
  end
  // Data word has no reset; the core reads it only after the flag
  always_ff @(negedge sclk) begin
    if (fcount == 5'h0F) begin
      x.rx_config <= {rxreg[14:0], serial_in};
    end
  end
endmodule : acs_link

/* File: hw/acs_top.sv */
// Mode control, conversion timing and ready pin of the converter
`timescale 1ns/100ps
`include "acs_cfg.svh"
module acs_top
  import acs_pkg::*;
#(
  parameter int TIMEOUT_CYC = `ACS_TIMEOUT_MS * (`ACS_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out_ready_pin_o,
  output logic serial_out_ready_pin_oe,
  // Converter front end
  input wire logic [15:0] adc_code,
  input wire logic [11:0] temp_code,
  output logic adc_powered,
  output logic temp_sensor_select,
  output logic [15:0] config_word
);
  localparam int OSC_DIV = `ACS_CLK_HZ / `ACS_OSC_HZ;
  localparam int EARLY_TICKS = `ACS_EARLY_US * (`ACS_OSC_HZ / 1000000);

  // ==========================================================
  // Crossing and link
  // ==========================================================
  acs_xfer_if x ();
  logic port_clear;
  logic shift_bit;
  acs_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .shift_bit(shift_bit),
    .port_clear(port_clear),
    .x(x.link)
  );
  logic cs_sel_s, sclk_s, cfg_s, start_s, shift_s;
  // Select sense synced so its reset value is the deselected level
  acs_sync u_cs (.clk(clk), .rst(rst), .din(~cs_n), .dout(cs_sel_s));
  wire cs_n_s = ~cs_sel_s;
  acs_sync u_sck (.clk(clk), .rst(rst), .din(sclk), .dout(sclk_s));
  acs_sync u_cfg (.clk(clk), .rst(rst), .din(x.cfg_seen),
    .dout(cfg_s));
  acs_sync u_st (.clk(clk), .rst(rst), .din(x.start_seen),
    .dout(start_s));
  acs_sync u_sh (.clk(clk), .rst(rst), .din(shift_bit), .dout(shift_s));
  logic cfg_d, start_d;
  wire cfg_evt = cfg_s & ~cfg_d;
  wire start_evt = start_s & ~start_d;

  // ==========================================================
  // Oscillator tick and data-rate period
  // ==========================================================
  function automatic logic [11:0] period_ticks(input logic [2:0] dr);
    unique case (dr)
      3'h0: period_ticks = 12'h1E8;
      3'h1: period_ticks = 12'h0F4;
      3'h2: period_ticks = 12'h07A;
      3'h3: period_ticks = 12'h03D;
      3'h4: period_ticks = 12'h01F;
      3'h5: period_ticks = 12'h014;
      3'h6: period_ticks = 12'h00F;
      3'h7: period_ticks = 12'h00F;
    endcase
  endfunction : period_ticks
  // Coarse units of 16 oscillator ticks keep the counter small
  logic [5:0] div;
  logic [3:0] sub;
  logic [11:0] units;
  wire osc_tick = (div == 6'(OSC_DIV - 1));
  wire unit_tick = osc_tick & (sub == 4'hF);

  // ==========================================================
  // Configuration and mode state
  // ==========================================================
  acs_word_t cfg, result;
  acs_state_t state;
  logic unread;
  wire [15:0] wr = x.rx_config;
  wire wr_ss = cfg_evt & wr[`ACS_BIT_SS];
  wire conv_done = (state != ACS_OFF) & unit_tick & (units == 12'h000);
  wire [15:0] next_cfg = {1'b0, wr[14:1], 1'b1};
  // A triggering write runs at the rate it carries
  wire [15:0] eff_cfg = cfg_evt ? next_cfg : cfg;
  wire [11:0] per = period_ticks(eff_cfg[`ACS_DR_HI:`ACS_DR_LO]);
  wire [15:0] sample = cfg[`ACS_BIT_TS] ?
    {temp_code, 4'h0} : {adc_code[15:4], 4'h0};
  // Last unit before a result; early window is limited to 16 ticks
  wire early = (state == ACS_RUN) & unread & (units == 12'h000) &
    (sub >= 4'(16 - EARLY_TICKS));
  logic [24:0] idle;
  wire timeout = (idle == 25'(TIMEOUT_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= `ACS_CFG_RESET;
      state <= ACS_OFF;
    end else begin
      if (cfg_evt) begin
        cfg <= next_cfg;
      end
      unique case (state)
        ACS_OFF: begin
          if (cfg_evt && !wr[`ACS_BIT_MODE]) begin
            state <= ACS_RUN;
          end else if (wr_ss) begin
            state <= ACS_CONV;
          end
        end
        ACS_CONV: begin
          if (conv_done) begin
            state <= (cfg[`ACS_BIT_MODE]) ? ACS_OFF : ACS_RUN;
          end
        end
        ACS_RUN: begin
          if (cfg_evt && wr[`ACS_BIT_MODE]) begin
            state <= ACS_OFF;
          end
        end
        default: begin
          state <= ACS_OFF;
        end
      endcase
    end
  end

  // Conversion counter; a trigger mid-conversion does not restart it
  always_ff @(posedge clk) begin
    if (rst) begin
      div <= 6'h00;
      sub <= 4'h0;
      units <= 12'h000;
    end else begin
      div <= osc_tick ? 6'h00 : div + 6'h01;
      if (osc_tick) begin
        sub <= sub + 4'h1;
      end
      if (state == ACS_OFF) begin
        units <= per;
        sub <= 4'h0;
      end else if (unit_tick) begin
        units <= (units == 12'h000) ? per : units - 12'h001;
      end
    end
  end

  // Result register and unread flag; new result wins over a read
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= 16'h0000;
      unread <= 1'b0;
      cfg_d <= 1'b0;
      start_d <= 1'b0;
    end else begin
      cfg_d <= cfg_s;
      start_d <= start_s;
      if (conv_done) begin
        result <= sample;
        unread <= 1'b1;
      end else if (start_evt) begin
        unread <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Serial clock low timeout
  // ==========================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      idle <= 25'h0000000;
      port_clear <= 1'b0;
    end else begin
      port_clear <= timeout;
      if (sclk_s || cs_n_s || timeout) begin
        idle <= 25'h0000000;
      end else begin
        idle <= idle + 25'h0000001;
      end
    end
  end

  // ==========================================================
  // Transfer tracking and ready pin
  // ==========================================================
  logic busy;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      serial_out_ready_pin_o <= 1'b1;
      serial_out_ready_pin_oe <= 1'b0;
      adc_powered <= 1'b0;
      temp_sensor_select <= 1'b0;
      config_word <= `ACS_CFG_RESET;
      x.tx_result <= 16'h0000;
    end else begin
      if (cs_n_s || port_clear) begin
        busy <= 1'b0;
      end else if (start_evt) begin
        busy <= 1'b1;
      end
      if (!busy && !start_evt) begin
        x.tx_result <= result;
      end
      serial_out_ready_pin_oe <= ~cs_n_s;
      if (busy) begin
        serial_out_ready_pin_o <= shift_s;
      end else begin
        serial_out_ready_pin_o <= ~unread | early;
      end
      adc_powered <= (state != ACS_OFF);
      temp_sensor_select <= cfg[`ACS_BIT_TS];
      config_word <= cfg;
    end
  end
endmodule : acs_top

/* File: tb/acs_top_properties.sv */
// Assertions on the converter control and serial pins
`timescale 1ns/100ps
module acs_top_properties #(
  parameter int TIMEOUT_CYC = 200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic serial_out_ready_pin_o,
  input wire logic serial_out_ready_pin_oe,
  // Converter front end
  input wire logic [15:0] adc_code,
  input wire logic [11:0] temp_code,
  input wire logic adc_powered,
  input wire logic temp_sensor_select,
  input wire logic [15:0] config_word
);
  // ==========================================================
  // Helper
  // Slowest rate is 489 units of 640 cycles, 312960 cycles; bound leaves margin
  logic [19:0] conv_cnt;
  always_ff @(posedge clk) begin
    if (rst || !(adc_powered && config_word[8])) conv_cnt <= 20'h0;
    else conv_cnt <= conv_cnt + 20'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Properties
  property p_reset_cfg;
    $fell(rst) |-> config_word == 16'h058B && !adc_powered;
  endproperty
  property p_reset_pin;
    $fell(rst) |-> serial_out_ready_pin_o && !serial_out_ready_pin_oe;
  endproperty
  property p_cs_off; cs_n [*5] |-> !serial_out_ready_pin_oe; endproperty
  property p_cs_on; $fell(cs_n) |-> ##[1:5] serial_out_ready_pin_oe;
  endproperty
  property p_ss_clear;
    $rose(adc_powered) && config_word[8] |->
      (adc_powered && !config_word[15]) [*8];
  endproperty
  property p_oe_track;
    serial_out_ready_pin_oe == !$past(cs_n, 3);
  endproperty
  property p_ss_bound; conv_cnt < 20'h61A80; endproperty
  property p_cont_run; (!config_word[8]) [*5] |-> adc_powered; endproperty
  property p_ts_sel; temp_sensor_select == config_word[4]; endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("config or power wrong after reset");
  a_reset_pin: assert property (p_reset_pin)
    else $error("pin driven after reset");
  a_cs_off: assert property (p_cs_off)
    else $error("pin driven while deselected");
  a_cs_on: assert property (p_cs_on)
    else $error("pin not driven after select");
  a_ss_clear: assert property (p_ss_clear)
    else $error("trigger bit did not start and clear");
  a_ss_bound: assert property (p_ss_bound)
    else $error("single conversion never ends");
  a_cont_run: assert property (p_cont_run)
    else $error("continuous mode not converting");
  a_ts_sel: assert property (p_ts_sel)
    else $error("sensor select differs from config");
  a_oe_track: assert property (p_oe_track)
    else $error("pin enable does not follow select");
  c_done: cover property ($fell(adc_powered));
  c_sel: cover property ($fell(cs_n));
  c_cont: cover property (!config_word[8] && adc_powered);
endmodule : acs_top_properties

bind acs_top acs_top_properties #(.TIMEOUT_CYC(TIMEOUT_CYC))
  acs_top_properties_i (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .serial_in(serial_in), .serial_out_ready_pin_o(serial_out_ready_pin_o),
  .serial_out_ready_pin_oe(serial_out_ready_pin_oe), .adc_code(adc_code),
  .temp_code(temp_code), .adc_powered(adc_powered),
  .temp_sensor_select(temp_sensor_select), .config_word(config_word));

/* File: tb/acs_host.sv */
// Host master model of the serial port
`timescale 1ns/100ps
module acs_host (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  // Pin as seen on the board
  input wire logic pin
);
  // ==========================================================
  // Master
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // Odd offset keeps the link unrelated in phase to clk
  task automatic sel(input logic lvl);
    #17;
    cs_n = lvl;
    #300;
  endtask : sel
  // Pin lags through a synchroniser, so sample late in the period
  task automatic shift(input logic [31:0] tx, input int n,
    output logic [31:0] r);
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      serial_in = tx[31 - i];
      #62.5;
      sclk = 1'b0;
      #61.5;
      r = {r[30:0], pin};
      #1;
    end
    serial_in = ~serial_in;
  endtask : shift
endmodule : acs_host

/* File: tb/tb_top.sv */
// Self-checking bench for the converter control and serial port
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic clk, rst, sclk, cs_n, serial_in, pin_o, pin_oe;
  logic adc_powered, temp_sensor_select;
  logic [15:0] adc_code, config_word;
  logic [11:0] temp_code;
  logic [31:0] rx;
  int miscompares = 0;
  int checks = 0;
  // Pull-up holds the pin high while deselected
  wire pin = pin_oe ? pin_o : 1'b1;
  acs_top #(.TIMEOUT_CYC(200)) acs_top_i (.clk(clk), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out_ready_pin_o(pin_o), .serial_out_ready_pin_oe(pin_oe),
    .adc_code(adc_code), .temp_code(temp_code), .adc_powered(adc_powered),
    .temp_sensor_select(temp_sensor_select), .config_word(config_word));
  acs_host acs_host_i (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .pin(pin));
  // ==========================================================
  // Helpers
  task automatic final_report;
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic wait_for(input logic use_pin, input logic lvl);
    int n;
    for (n = 0; n < 40000 && (use_pin ? pin : adc_powered) !== lvl; n++) begin
      @(posedge clk);
      #1;
    end
    if ((use_pin ? pin : adc_powered) !== lvl) begin
      miscompares++;
      final_report();
    end
  endtask : wait_for
  task automatic xfer(input logic [31:0] tx, input int n);
    acs_host_i.sel(1'b0);
    acs_host_i.shift(tx, n, rx);
    acs_host_i.sel(1'b1);
  endtask : xfer
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    `CHK(config_word, 16'h058B)
    `CHK(adc_powered, 1'b0)
    `CHK(pin_oe, 1'b0)
  endtask : t_reset
  task automatic t_single;
    acs_host_i.sel(1'b0);
    `CHK(pin, 1'b1)
    `CHK(pin_oe, 1'b1)
    acs_host_i.shift({16'h85FB, 16'h85FB}, 32, rx);
    acs_host_i.sel(1'b1);
    wait_for(1'b0, 1'b1);
    `CHK(config_word, 16'h05FB)
    `CHK(temp_sensor_select, 1'b1)
    xfer({16'h85FB, 16'h85FB}, 32);
    wait_for(1'b0, 1'b0);
    repeat (400) @(posedge clk);
    #1;
    `CHK(adc_powered, 1'b0)
    acs_host_i.sel(1'b0);
    `CHK(pin, 1'b0)
    acs_host_i.shift({16'h05DB, 16'h05DB}, 32, rx);
    acs_host_i.sel(1'b1);
    // Minus 40 C at 0.125 C per step
    `CHK(rx[31:16], {12'(-320), 4'h0})
    `CHK(rx[15:0], 16'h05DB)
  endtask : t_single
  task automatic t_cont;
    @(posedge clk);
    #1;
    adc_code = 16'h123F;
    xfer({16'h04EB, 16'h04EB}, 32);
    acs_host_i.sel(1'b0);
    wait_for(1'b1, 1'b0);
    acs_host_i.shift({16'h04EB, 16'h0000}, 16, rx);
    `CHK(rx[15:0], 16'h1230)
    `CHK(adc_powered, 1'b1)
    `CHK(temp_sensor_select, 1'b0)
  endtask : t_cont
  task automatic t_timeout;
    acs_host_i.shift(32'hFFFF_FFFF, 5, rx);
    repeat (300) @(posedge clk);
    acs_host_i.shift({16'h05EB, 16'h0000}, 16, rx);
    acs_host_i.sel(1'b1);
    `CHK(rx[15:0], 16'h1230)
    wait_for(1'b0, 1'b0);
    `CHK(config_word[8], 1'b1)
  endtask : t_timeout
  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    adc_code = 16'h7FFF;
    temp_code = 12'hEC0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_single();
    t_cont();
    t_timeout();
    final_report();
  end
endmodule : tb_top
